/* File: hw/cpgc_cfg.svh */
// Constants of the clock generator control block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and cpgc_top.
`ifndef CPGC_CFG_SVH
`define CPGC_CFG_SVH

// Register index; byte address is four times the index
`define CPGC_REG_INDEX 30'h0000fff5
`define CPGC_REG_WIDTH 8

// Field positions of clock_gen_control
`define CPGC_BIT_SUB_OSC_STOP 7
`define CPGC_BIT_RSVD_ZERO 6
`define CPGC_BIT_SPARE_HI 5
`define CPGC_BIT_SPARE_LO 3
`define CPGC_BIT_BOOT_SELECT 2
`define CPGC_BIT_ACTIVE_OSC 1
`define CPGC_BIT_RSVD_LOW 0

// Reset values
`define CPGC_RST_SUB_OSC_STOP 1'h0
`define CPGC_RST_SPARE 3'h0
`define CPGC_RST_RSVD_LOW 1'h0
`define CPGC_RST_BOOT_SELECT 1'h0

// Divider widths
`define CPGC_SYS_DIV_BITS 13
`define CPGC_WATCH_DIV_BITS 7

// AHB transfer type and response
`define CPGC_HTRANS_NONSEQ 2'h2
`define CPGC_HRESP_OKAY 1'h0

`endif

/* File: hw/cpgc_pkg.sv */
// Types of the clock generator control block.
// Assumes cpgc_cfg.svh on the include path.
`include "cpgc_cfg.svh"

package cpgc_pkg;

    typedef enum logic [0:0] {
        CPGC_CAPTURE = 1'b0,
        CPGC_RUN = 1'b1
    } cpgc_boot_e;

    typedef struct packed {
        logic sub_osc_stop;
        logic [2:0] spare;
        logic rsvd_low;
    } cpgc_ctrl_s;

    typedef struct packed {
        logic boot_select_level_flag;
        logic active_osc_flag;
    } cpgc_status_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
    } cpgc_dphase_s;

endpackage : cpgc_pkg

/* File: hw/cpgc_divider.sv */
// Binary ripple-free divider: each bit n toggles at input rate / 2^(n+1).
// Assumes the caller supplies a one-cycle advance strobe on hclk.
`timescale 1ns/1ps

module cpgc_divider #(
    parameter int WIDTH = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic advance,
    output logic [WIDTH-1:0] taps
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (advance)
        begin
            next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign taps = count;

endmodule : cpgc_divider

/* File: hw/cpgc_top.sv */
// Clock generator control: oscillator selection, dividers, one control register.
// Assumes an AHB-Lite master on hclk and pin levels synchronous to hclk.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "cpgc_cfg.svh"

module cpgc_top #(
    parameter int SYS_DIV_BITS = `CPGC_SYS_DIV_BITS,
    parameter int WATCH_DIV_BITS = `CPGC_WATCH_DIV_BITS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_select_pin,
    input wire logic ext_osc_in,
    input wire logic onchip_osc_in,
    input wire logic sub_osc_in,
    output logic ext_osc_enable,
    output logic onchip_osc_enable,
    output logic sub_osc_enable,
    output logic osc_clk,
    output logic sys_clk,
    output logic sub_clk,
    output logic watch_clk,
    output logic [SYS_DIV_BITS-1:0] sys_div_taps,
    output logic [WATCH_DIV_BITS-1:0] watch_div_taps
);

    ////////////////////////////////////////////////////////////////////////////
    // Register read image

    function automatic logic [`CPGC_REG_WIDTH-1:0] reg_image(
        input cpgc_pkg::cpgc_ctrl_s c,
        input cpgc_pkg::cpgc_status_s s
    );
        logic [`CPGC_REG_WIDTH-1:0] v;
        v = '0;
        v[`CPGC_BIT_SUB_OSC_STOP] = c.sub_osc_stop;
        v[`CPGC_BIT_RSVD_ZERO] = 1'b0;
        v[`CPGC_BIT_SPARE_HI:`CPGC_BIT_SPARE_LO] = c.spare;
        v[`CPGC_BIT_BOOT_SELECT] = s.boot_select_level_flag;
        v[`CPGC_BIT_ACTIVE_OSC] = s.active_osc_flag;
        v[`CPGC_BIT_RSVD_LOW] = c.rsvd_low;
        return v;
    endfunction : reg_image

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: address phase capture, zero-wait data phase
    // Read data is built in the address phase: a read right behind a write
    // to the register returns the value from before that write.

    cpgc_pkg::cpgc_dphase_s dphase;
    cpgc_pkg::cpgc_dphase_s next_dphase;
    cpgc_pkg::cpgc_ctrl_s ctrl;
    cpgc_pkg::cpgc_ctrl_s next_ctrl;
    cpgc_pkg::cpgc_status_s status;
    cpgc_pkg::cpgc_status_s next_status;
    cpgc_pkg::cpgc_boot_e boot_state;
    cpgc_pkg::cpgc_boot_e next_boot_state;
    logic [31:0] next_hrdata;
    logic addr_take;
    logic addr_hit;

    always_comb
    begin
        addr_take = hsel && hready && (htrans == `CPGC_HTRANS_NONSEQ);
        addr_hit = (haddr[31:2] == `CPGC_REG_INDEX);
        next_dphase.valid = addr_take;
        next_dphase.write = addr_take && hwrite;
        next_dphase.hit = addr_take && addr_hit;
        next_hrdata = hrdata;
        if (addr_take && !hwrite)
        begin
            // Unmapped reads return zero with OKAY
            next_hrdata = 32'h00000000;
            if (addr_hit)
            begin
                // Next flags, so a read taken in the capture cycle already sees the strap
                next_hrdata[`CPGC_REG_WIDTH-1:0] = reg_image(ctrl, next_status);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dphase <= '0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= `CPGC_HRESP_OKAY;
        end
        else
        begin
            dphase <= next_dphase;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= `CPGC_HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable control fields

    always_comb
    begin
        next_ctrl = ctrl;
        if (dphase.valid && dphase.write && dphase.hit)
        begin
            // No guard on mode: a stop in subactive mode is software's fault
            next_ctrl.sub_osc_stop = hwdata[`CPGC_BIT_SUB_OSC_STOP];
            next_ctrl.spare = hwdata[`CPGC_BIT_SPARE_HI:`CPGC_BIT_SPARE_LO];
            // Stored only; it steers nothing
            next_ctrl.rsvd_low = hwdata[`CPGC_BIT_RSVD_LOW];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl.sub_osc_stop <= `CPGC_RST_SUB_OSC_STOP;
            ctrl.spare <= `CPGC_RST_SPARE;
            ctrl.rsvd_low <= `CPGC_RST_RSVD_LOW;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator selection caught once at reset release

    logic next_ext_osc_enable;
    logic next_onchip_osc_enable;

    always_comb
    begin
        next_boot_state = boot_state;
        next_status = status;
        next_ext_osc_enable = ext_osc_enable;
        next_onchip_osc_enable = onchip_osc_enable;
        case (boot_state)
            cpgc_pkg::CPGC_CAPTURE:
            begin
                // Pin must be strapped, so one sample is enough
                next_status.boot_select_level_flag = osc_select_pin;
                next_status.active_osc_flag = osc_select_pin;
                next_ext_osc_enable = !osc_select_pin;
                next_onchip_osc_enable = osc_select_pin;
                next_boot_state = cpgc_pkg::CPGC_RUN;
            end
            cpgc_pkg::CPGC_RUN:
            begin
                next_boot_state = cpgc_pkg::CPGC_RUN;
            end
            default:
            begin
                next_boot_state = cpgc_pkg::CPGC_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            boot_state <= cpgc_pkg::CPGC_CAPTURE;
            status <= '0;
            // External oscillator is the default until the strap is seen
            ext_osc_enable <= 1'b1;
            onchip_osc_enable <= 1'b0;
        end
        else
        begin
            boot_state <= next_boot_state;
            status <= next_status;
            ext_osc_enable <= next_ext_osc_enable;
            onchip_osc_enable <= next_onchip_osc_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System path: oscillator clock, system clock, prescaler

    logic next_osc_clk;
    logic next_sys_clk;

    always_comb
    begin
        // Only the enabled source is passed; the other stays silent
        next_osc_clk = status.active_osc_flag ? onchip_osc_in : ext_osc_in;
        if (boot_state == cpgc_pkg::CPGC_CAPTURE)
        begin
            next_osc_clk = 1'b0;
        end
        next_sys_clk = osc_clk;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_clk <= 1'b0;
            sys_clk <= 1'b0;
        end
        else
        begin
            osc_clk <= next_osc_clk;
            sys_clk <= next_sys_clk;
        end
    end

    // Taps counted on every hclk cycle; bit n is hclk divided by 2^(n+1)
    cpgc_divider #(
        .WIDTH(SYS_DIV_BITS)
    ) u_sys_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .advance(1'b1),
        .taps(sys_div_taps)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Subclock path: gated oscillator, watch clock, watch divider

    logic sub_level;
    logic next_sub_level;
    logic next_sub_osc_enable;
    logic next_watch_clk;
    logic next_sub_clk;
    logic watch_rise;

    always_comb
    begin
        // Stop only gates the level here; a real oscillator restarts slowly
        // and software must allow for that before trusting the subclock.
        next_sub_osc_enable = !ctrl.sub_osc_stop;
        // Stopped oscillator holds low so the watch divider freezes
        next_sub_level = sub_osc_enable ? sub_osc_in : 1'b0;
        watch_rise = next_sub_level && !sub_level;
        next_watch_clk = sub_level;
        next_sub_clk = sub_level;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sub_osc_enable <= 1'b1;
            sub_level <= 1'b0;
            watch_clk <= 1'b0;
            sub_clk <= 1'b0;
        end
        else
        begin
            sub_osc_enable <= next_sub_osc_enable;
            sub_level <= next_sub_level;
            watch_clk <= next_watch_clk;
            sub_clk <= next_sub_clk;
        end
    end

    // Bit n is the watch clock divided by 2^(n+1), up to /128
    cpgc_divider #(
        .WIDTH(WATCH_DIV_BITS)
    ) u_watch_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .advance(watch_rise),
        .taps(watch_div_taps)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Unused bus inputs kept visible for readers: hsize is not checked,
    // every access is treated as a whole word.

endmodule : cpgc_top

/* File: testbench/cpgc_monitor.sv */
// Checker of the clock generator control block, bound to cpgc_top.
// Assumes zero wait states and the register at byte address 3ffd4.
`timescale 1ns/1ps

module cpgc_monitor #(
    parameter int SYS_DIV_BITS = 13
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic osc_select_pin,
    input wire logic ext_osc_enable,
    input wire logic onchip_osc_enable,
    input wire logic sub_osc_enable,
    input wire logic [SYS_DIV_BITS-1:0] sys_div_taps
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////////
    cpgc_pkg::cpgc_dphase_s dp;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dp <= '0;
        else if (hready)
            dp <= '{hsel && htrans == 2'h2, hwrite, haddr[31:2] == 30'h0000fff5};
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_WRITE_STOP: assert property (dp.valid && dp.write && dp.hit |->
        ##2 sub_osc_enable == !$past(hwdata[7], 2))
        else $error("subclock enable does not follow stop bit");
    // Capture edge is the first one after release, so look one edge later
    AST_STRAP_CAPTURE: assert property (!$past(hresetn, 2) && $past(hresetn) |->
        onchip_osc_enable == $past(osc_select_pin))
        else $error("oscillator choice differs from strap");
    AST_FLAG_HOLD: assert property ($past(hresetn, 2) |->
        $stable(onchip_osc_enable) && $stable(ext_osc_enable))
        else $error("oscillator choice changed after capture");
    AST_OSC_EXCLUSIVE: assert property (ext_osc_enable != onchip_osc_enable)
        else $error("both or neither system oscillator enabled");
    AST_READ_FLAGS: assert property (dp.valid && !dp.write && dp.hit |->
        hrdata[2:1] == {2{onchip_osc_enable}} && hrdata[6] == 1'b0 && hrdata[31:8] == 24'h0)
        else $error("read flags disagree with oscillator choice");
    AST_UNMAPPED: assert property (dp.valid && !dp.write && !dp.hit |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_TAP_STEP: assert property ($past(hresetn, 2) |->
        sys_div_taps == SYS_DIV_BITS'($past(sys_div_taps) + 1'b1))
        else $error("system divider did not advance by one");

    cover property (dp.valid && dp.write && dp.hit);
    cover property (dp.valid && !dp.write && dp.hit);
    cover property (onchip_osc_enable);
endmodule : cpgc_monitor

/* File: testbench/clock_pulse_gen_control_tb_top.sv */
// Self-checking bench of the clock generator control block.
// Assumes cpgc_top with hready tied back from hreadyout.
`timescale 1ns/1ps

module clock_pulse_gen_control_tb_top;
    localparam logic [31:0] REG_ADDR = 32'h0003ffd4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic osc_select_pin = 1'b0;
    logic ext_osc_in = 1'b0;
    logic onchip_osc_in = 1'b0;
    logic sub_osc_in = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, ext_osc_enable, onchip_osc_enable, sub_osc_enable;
    logic osc_clk, sys_clk, sub_clk, watch_clk;
    logic [12:0] sys_div_taps;
    logic [6:0] watch_div_taps;
    int miscompares = 0;
    int n_tests = 0;

    always #25 hclk = ~hclk;

    cpgc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_select_pin(osc_select_pin),
        .ext_osc_in(ext_osc_in), .onchip_osc_in(onchip_osc_in), .sub_osc_in(sub_osc_in),
        .ext_osc_enable(ext_osc_enable), .onchip_osc_enable(onchip_osc_enable),
        .sub_osc_enable(sub_osc_enable), .osc_clk(osc_clk), .sys_clk(sys_clk),
        .sub_clk(sub_clk), .watch_clk(watch_clk), .sys_div_taps(sys_div_taps),
        .watch_div_taps(watch_div_taps));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : bus

    // Strap flips after capture so a flag that keeps sampling shows up
    task automatic do_reset(input logic pin);
        @(posedge hclk);
        hresetn <= 1'b0;
        osc_select_pin <= pin;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        osc_select_pin <= ~pin;
    endtask : do_reset

    task automatic sub_pulses();
        @(posedge hclk);
        repeat (4)
        begin
            sub_osc_in <= 1'b1;
            repeat (2) @(posedge hclk);
            sub_osc_in <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (4) @(negedge hclk);
    endtask : sub_pulses

    // Raise the subclock input and look at both subclock outputs
    task automatic sub_hold(input logic [1:0] exp);
        @(posedge hclk);
        sub_osc_in <= 1'b1;
        repeat (3) @(negedge hclk);
        check({sub_clk, watch_clk}, exp);
        @(posedge hclk);
        sub_osc_in <= 1'b0;
    endtask : sub_hold

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_strap_low();
        logic [31:0] r;
        do_reset(1'b0);
        bus(1'b0, REG_ADDR, 32'h0, r);
        check(r, 32'h0);
        check(ext_osc_enable, 1'b1);
        check(onchip_osc_enable, 1'b0);
        check(sub_osc_enable, 1'b1);
        ext_osc_in <= 1'b1;
        repeat (3) @(negedge hclk);
        check({osc_clk, sys_clk}, 2'h3);
        @(posedge hclk);
        ext_osc_in <= 1'b0;
    endtask : t_strap_low

    task automatic t_regs();
        logic [31:0] r;
        bus(1'b1, REG_ADDR, 32'hfffffffe, r);
        bus(1'b0, REG_ADDR, 32'h0, r);
        check(r, 32'hb8);
        check(sub_osc_enable, 1'b0);
        bus(1'b1, REG_ADDR, 32'h0, r);
        bus(1'b0, REG_ADDR, 32'h0, r);
        check(r, 32'h0);
        check(sub_osc_enable, 1'b1);
    endtask : t_regs

    task automatic t_unmapped();
        logic [31:0] r;
        bus(1'b1, REG_ADDR - 32'h4, 32'h38, r);
        bus(1'b0, REG_ADDR - 32'h4, 32'h0, r);
        check(r, 32'h0);
        bus(1'b0, REG_ADDR, 32'h0, r);
        check(r, 32'h0);
    endtask : t_unmapped

    // A stopped subclock must freeze the watch divider
    task automatic t_watch();
        logic [31:0] r;
        logic [6:0] w0;
        @(negedge hclk);
        w0 = watch_div_taps;
        sub_pulses();
        check(7'(watch_div_taps - w0), 7'h4);
        sub_hold(2'h3);
        bus(1'b1, REG_ADDR, 32'h80, r);
        repeat (4) @(negedge hclk);
        w0 = watch_div_taps;
        sub_pulses();
        check(7'(watch_div_taps - w0), 7'h0);
        sub_hold(2'h0);
        // Restart; nothing uses the subclock afterwards, as it needs time to settle
        bus(1'b1, REG_ADDR, 32'h0, r);
    endtask : t_watch

    task automatic t_taps();
        logic [12:0] s;
        @(negedge hclk);
        s = sys_div_taps;
        repeat (5) @(negedge hclk);
        check(sys_div_taps, 13'(s + 13'h5));
    endtask : t_taps

    task automatic t_strap_high();
        logic [31:0] r;
        do_reset(1'b1);
        bus(1'b0, REG_ADDR, 32'h0, r);
        check(r, 32'h6);
        check({ext_osc_enable, onchip_osc_enable}, 2'h1);
        ext_osc_in <= 1'b1;
        repeat (3) @(negedge hclk);
        check(osc_clk, 1'b0);
        @(posedge hclk);
        onchip_osc_in <= 1'b1;
        repeat (3) @(negedge hclk);
        check(osc_clk, 1'b1);
    endtask : t_strap_high

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial
    begin
        t_strap_low();
        t_regs();
        t_unmapped();
        t_watch();
        t_taps();
        t_strap_high();
        final_report();
    end

    // Whole run is under two hundred cycles
    initial
    begin
        #250000;
        miscompares++;
        final_report();
    end
endmodule : clock_pulse_gen_control_tb_top

bind cpgc_top cpgc_monitor #(.SYS_DIV_BITS(SYS_DIV_BITS)) i_mon (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_select_pin(osc_select_pin), .ext_osc_enable(ext_osc_enable),
    .onchip_osc_enable(onchip_osc_enable), .sub_osc_enable(sub_osc_enable),
    .sys_div_taps(sys_div_taps));
